// >>> dv/bobt_core_bench.sv
`default_nettype none
// ****************************************
// Instruction bench over the register bus
// ****************************************
module bobt_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic cyc, stb, we, ack, busy;
	logic [11:0] adr;
	logic [3:0] sel;
	logic [31:0] dw, dr, rv;
	int fails = 0;
	int checked = 0;
	int ticks = 0;
	int busy_seen = 0;
	always #2 mclk = ~mclk;
	// Counted on the falling edge, where busy has settled
	always @(negedge mclk) begin
		if (busy === 1'b1) begin
			busy_seen++;
		end
	end
	bobt_core bobt_core_inst (.MCLK(mclk), .NRST(nrst), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack), .BUSY(busy));
	bobt_wb_host bobt_wb_host_inst (.MCLK(mclk), .WB_ACK_O(ack),
		.WB_DAT_O(dr), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw));
	function automatic logic [11:0] rf(input logic [7:0] i);
		return {bobt_pkg::RF_WINDOW, i, 2'b00};
	endfunction : rf
	task automatic test_done();
		$display("Compares %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bobt_wb_host_inst.xfer(1'b1, a, d, rv);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bobt_wb_host_inst.xfer(1'b0, a, 32'h0, rv);
		chk(rv, e);
	endtask : rd
	// Busy cycles counted over a fixed window longer than any opcode
	task automatic run(input logic [31:0] insn, input logic [3:0] n);
		wr(bobt_pkg::OFS_INSN, insn);
		busy_seen = 0;
		wr(bobt_pkg::OFS_CTRL, 32'h3);
		repeat (20) @(negedge mclk);
		chk(32'(busy_seen), {28'h0, n});
	endtask : run
	always @(posedge mclk) begin
		ticks++;
		if (ticks == 4000) begin
			fails++;
			test_done();
		end
	end
	initial begin
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		rd(bobt_pkg::OFS_RP, 32'hC0);
		rd(12'h0F0, 32'h0);
		wr(rf(8'hC1), 32'h06);
		wr(rf(8'h01), 32'h03);
		wr(bobt_pkg::OFS_FLAGS, 32'hFF);
		wr(bobt_pkg::OFS_PC, 32'h10);
		run(32'h00071201, bobt_pkg::BITOR_CYCLES);
		rd(rf(8'hC1), 32'h07);
		rd(rf(8'h01), 32'h03);
		rd(bobt_pkg::OFS_FLAGS, 32'h9F);
		rd(bobt_pkg::OFS_PC, 32'h13);
		wr(rf(8'hC1), 32'h06);
		run(32'h00071501, bobt_pkg::BITOR_CYCLES);
		rd(rf(8'h01), 32'h03);
		rd(rf(8'hC1), 32'h06);
		rd(bobt_pkg::OFS_FLAGS, 32'hDF);
		wr(rf(8'hC1), 32'h07);
		wr(bobt_pkg::OFS_FLAGS, 32'hA4);
		run(32'h003716FE, bobt_pkg::BTJ_CYCLES);
		rd(bobt_pkg::OFS_PC, 32'h17);
		rd(bobt_pkg::OFS_STATUS, 32'h0A);
		rd(bobt_pkg::OFS_FLAGS, 32'hA4);
		// Tested bit set: branch falls through
		run(32'h0037127F, bobt_pkg::BTJ_CYCLES);
		rd(bobt_pkg::OFS_PC, 32'h1A);
		rd(bobt_pkg::OFS_STATUS, 32'h02);
		rd(bobt_pkg::OFS_FLAGS, 32'hA4);
		run(32'h00371301, 4'h0);
		rd(bobt_pkg::OFS_STATUS, 32'h04);
		rd(bobt_pkg::OFS_PC, 32'h1A);
		rd(rf(8'hC1), 32'h07);
		// Both ends of the allowed displacement range, taken
		run(32'h0037167F, bobt_pkg::BTJ_CYCLES);
		rd(bobt_pkg::OFS_PC, 32'h9C);
		run(32'h00371680, bobt_pkg::BTJ_CYCLES);
		rd(bobt_pkg::OFS_PC, 32'h1F);
		rd(bobt_pkg::OFS_STATUS, 32'h0A);
		test_done();
	end
endmodule : bobt_core_bench
`default_nettype wire

// >>> dv/bobt_wb_host.sv
`default_nettype none
// ****************************************
// Wishbone classic master, software side
// ****************************************
module bobt_wb_host (
	input wire logic MCLK,
	input wire logic WB_ACK_O,
	input wire logic [31:0] WB_DAT_O,
	output logic WB_CYC_I,
	output logic WB_STB_I,
	output logic WB_WE_I,
	output logic [11:0] WB_ADR_I,
	output logic [3:0] WB_SEL_I,
	output logic [31:0] WB_DAT_I
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		WB_CYC_I = 1'b0;
		WB_STB_I = 1'b0;
		WB_WE_I = 1'b0;
		WB_ADR_I = 12'h000;
		WB_SEL_I = 4'h0;
		WB_DAT_I = 32'h0;
	end
	// Request held until ack sampled, so no cycle count assumed
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge MCLK);
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= w;
		WB_ADR_I <= a;
		WB_SEL_I <= 4'hF;
		WB_DAT_I <= d;
		do @(posedge MCLK); while (WB_ACK_O !== 1'b1);
		q = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		WB_WE_I <= 1'b0;
	endtask : xfer
endmodule : bobt_wb_host
`default_nettype wire

// >>> hdl/bobt_core.sv
// Behaviour
// - OR selected bit with operand bit 0
// - Only destination bit changes; source untouched
// - Z set on zero result, S cleared
// - Bit-OR: opcode 07, three bytes, 6 cycles
// - Byte two: register, bit index, selector
// - Branch by displacement when tested bit clear
// - Bit-clear branch touches no flags
// - Branch: opcode 37, three bytes, 10 cycles
// - Branch byte two: source, bit, low field
`default_nettype none
module bobt_core (
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [11:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic BUSY
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		bobt_pkg::bobt_state_t state;
		bobt_pkg::bobt_kind_t kind;
		logic [3:0] cnt;
		logic busy;
		logic done;
		logic bad;
		logic taken;
		logic [23:0] insn;
		logic [15:0] pc;
		logic [7:0] flags;
		logic [7:0] rp;
		logic [255:0][7:0] mem;
		logic ack;
		logic [31:0] rdat;
	} bobt_st_t;

	bobt_st_t st_r;
	bobt_st_t st_nxt;

	logic [7:0] opc;
	logic [3:0] wreg;
	logic [2:0] bsel;
	logic lsb;
	logic [7:0] b3;
	logic [7:0] w_idx;
	logic [7:0] dst_idx;
	logic [7:0] src_idx;
	logic [7:0] dst_val;
	logic [7:0] src_val;
	logic res_bit;
	logic [7:0] bitor_new;
	logic tested;
	logic [15:0] pc_next;
	logic [15:0] pc_jump;
	logic commit_bitor;
	logic commit_btj;
	logic start_bitor;
	logic start_btj;
	logic bus_req;
	logic bus_wr;
	logic go_wr;
	logic clr_wr;
	logic rf_hit;
	logic [7:0] rf_idx;
	logic [31:0] wmask;

	// ****************************************
	// Operand decode
	// ****************************************
	assign opc = st_r.insn[23:16];
	assign wreg = st_r.insn[15:12];
	assign bsel = st_r.insn[11:9];
	assign lsb = st_r.insn[8];
	assign b3 = st_r.insn[7:0];
	assign w_idx = {st_r.rp[7:4], wreg};
	// Selector picks which side holds the indexed bit
	assign dst_idx = lsb ? b3 : w_idx;
	assign src_idx = lsb ? w_idx : b3;
	assign dst_val = st_r.mem[dst_idx];
	assign src_val = st_r.mem[src_idx];
	always_comb begin
		bitor_new = dst_val;
		if (lsb) begin
			res_bit = dst_val[bsel] | src_val[0];
			bitor_new[bsel] = res_bit;
		end else begin
			res_bit = dst_val[0] | src_val[bsel];
			bitor_new[0] = res_bit;
		end
	end
	assign tested = st_r.mem[w_idx][bsel];
	assign pc_next = st_r.pc + bobt_pkg::INSN_LEN;
	assign pc_jump = pc_next + {{8{b3[7]}}, b3};

	// ****************************************
	// Bus decode
	// ****************************************
	assign bus_req = WB_CYC_I & WB_STB_I & ~st_r.ack;
	assign bus_wr = bus_req & WB_WE_I;
	assign rf_hit = WB_ADR_I[11:10] == bobt_pkg::RF_WINDOW;
	assign rf_idx = WB_ADR_I[9:2];
	assign go_wr = bus_wr & (WB_ADR_I == bobt_pkg::OFS_CTRL) & WB_SEL_I[0]
		& WB_DAT_I[bobt_pkg::CTRL_GO];
	assign clr_wr = bus_wr & (WB_ADR_I == bobt_pkg::OFS_CTRL) & WB_SEL_I[0]
		& WB_DAT_I[bobt_pkg::CTRL_CLR];
	assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
		{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
	// Branch-on-set shares 37 but has low field 1; not ours
	assign start_bitor = go_wr & ~st_r.busy
		& (opc == bobt_pkg::OPC_BITOR);
	assign start_btj = go_wr & ~st_r.busy & (opc == bobt_pkg::OPC_BTJ)
		& ~lsb;
	assign commit_bitor = st_r.busy & (st_r.cnt == 4'h0)
		& (st_r.kind == bobt_pkg::BOBT_K_BITOR);
	assign commit_btj = st_r.busy & (st_r.cnt == 4'h0)
		& (st_r.kind == bobt_pkg::BOBT_K_BTJ);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = bus_req;
		st_nxt.rdat = 32'h0000_0000;
		// Reads answer in one cycle; unmapped words read zero
		if (bus_req && !WB_WE_I) begin
			if (rf_hit) begin
				st_nxt.rdat = {24'h00_0000, st_r.mem[rf_idx]};
			end else begin
				case (WB_ADR_I)
				bobt_pkg::OFS_INSN: st_nxt.rdat = {8'h00, st_r.insn};
				bobt_pkg::OFS_PC: st_nxt.rdat = {16'h0000, st_r.pc};
				bobt_pkg::OFS_FLAGS: st_nxt.rdat = {24'h00_0000, st_r.flags};
				bobt_pkg::OFS_RP: st_nxt.rdat = {24'h00_0000, st_r.rp};
				bobt_pkg::OFS_STATUS: begin
					st_nxt.rdat[bobt_pkg::ST_BUSY] = st_r.busy;
					st_nxt.rdat[bobt_pkg::ST_DONE] = st_r.done;
					st_nxt.rdat[bobt_pkg::ST_BAD] = st_r.bad;
					st_nxt.rdat[bobt_pkg::ST_TAKEN] = st_r.taken;
				end
				default: st_nxt.rdat = 32'h0000_0000;
				endcase
			end
		end
		// Writes to live state are dropped while busy, so operands hold
		if (bus_wr && !st_r.busy) begin
			if (rf_hit) begin
				if (WB_SEL_I[0]) begin
					st_nxt.mem[rf_idx] = WB_DAT_I[7:0];
				end
			end else begin
				case (WB_ADR_I)
				bobt_pkg::OFS_INSN: st_nxt.insn =
					(st_r.insn & ~wmask[23:0]) | (WB_DAT_I[23:0] & wmask[23:0]);
				bobt_pkg::OFS_PC: st_nxt.pc =
					(st_r.pc & ~wmask[15:0]) | (WB_DAT_I[15:0] & wmask[15:0]);
				bobt_pkg::OFS_FLAGS: begin
					if (WB_SEL_I[0]) begin
						st_nxt.flags = WB_DAT_I[7:0];
					end
				end
				bobt_pkg::OFS_RP: begin
					if (WB_SEL_I[0]) begin
						st_nxt.rp = WB_DAT_I[7:0];
					end
				end
				default: st_nxt.rp = st_r.rp;
				endcase
			end
		end
		if (clr_wr) begin
			st_nxt.done = 1'b0;
			st_nxt.bad = 1'b0;
		end
		case (st_r.state)
		bobt_pkg::BOBT_IDLE: begin
			if (start_bitor) begin
				st_nxt.state = bobt_pkg::BOBT_EXEC;
				st_nxt.kind = bobt_pkg::BOBT_K_BITOR;
				st_nxt.cnt = bobt_pkg::BITOR_CYCLES - 4'h1;
				st_nxt.busy = 1'b1;
				st_nxt.taken = 1'b0;
			end else if (start_btj) begin
				st_nxt.state = bobt_pkg::BOBT_EXEC;
				st_nxt.kind = bobt_pkg::BOBT_K_BTJ;
				st_nxt.cnt = bobt_pkg::BTJ_CYCLES - 4'h1;
				st_nxt.busy = 1'b1;
				st_nxt.taken = 1'b0;
			end else if (go_wr) begin
				// Foreign opcode: flagged, nothing executed
				st_nxt.bad = 1'b1;
			end
		end
		bobt_pkg::BOBT_EXEC: begin
			if (st_r.cnt != 4'h0) begin
				st_nxt.cnt = st_r.cnt - 4'h1;
			end else begin
				st_nxt.state = bobt_pkg::BOBT_IDLE;
				st_nxt.busy = 1'b0;
				// Completion beats a clear in the same cycle
				st_nxt.done = 1'b1;
				if (st_r.kind == bobt_pkg::BOBT_K_BITOR) begin
					st_nxt.mem[dst_idx] = bitor_new;
					st_nxt.flags[bobt_pkg::FL_Z] = ~res_bit;
					st_nxt.flags[bobt_pkg::FL_S] = 1'b0;
					st_nxt.pc = pc_next;
				end else begin
					// Flags left alone either way
					st_nxt.pc = tested ? pc_next : pc_jump;
					st_nxt.taken = ~tested;
				end
			end
		end
		default: begin
			st_nxt.state = bobt_pkg::BOBT_IDLE;
			st_nxt.busy = 1'b0;
		end
		endcase
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			st_r <= '0;
			st_r.pc <= bobt_pkg::PC_RST;
			st_r.flags <= bobt_pkg::FLAGS_RST;
			st_r.rp <= bobt_pkg::RP_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign WB_DAT_O = st_r.rdat;
	assign WB_ACK_O = st_r.ack;
	assign BUSY = st_r.busy;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!NRST);

	sequence s_bitor_run;
		st_r.busy [*6] ##1 !st_r.busy;
	endsequence
	sequence s_btj_run;
		st_r.busy [*8] ##1 st_r.busy [*2] ##1 !st_r.busy;
	endsequence

	// Expected bytes rebuilt from the old operands, not from bitor_new
	a_or_low_form: assert property (
		commit_bitor && !lsb
		|=> st_r.mem[$past(w_idx)] == ($past(st_r.mem[w_idx])
		| {7'h00, $past(st_r.mem[b3][bsel])}))
		else $error("bit-or low-bit form wrong");
	a_or_bit_form: assert property (
		commit_bitor && lsb
		|=> st_r.mem[$past(b3)] == ($past(st_r.mem[b3])
		| ({7'h00, $past(st_r.mem[w_idx][0])} << $past(bsel))))
		else $error("bit-or indexed-bit form wrong");
	a_bitor_src_keep: assert property (
		commit_bitor && (src_idx != dst_idx)
		|=> st_r.mem[$past(src_idx)] == $past(src_val))
		else $error("bit-or source disturbed");
	a_bitor_flag_set: assert property (
		commit_bitor |=> st_r.flags[bobt_pkg::FL_Z] == !$past(res_bit)
		&& !st_r.flags[bobt_pkg::FL_S]
		&& st_r.flags[bobt_pkg::FL_C] == $past(st_r.flags[bobt_pkg::FL_C])
		&& st_r.flags[bobt_pkg::FL_D] == $past(st_r.flags[bobt_pkg::FL_D])
		&& st_r.flags[bobt_pkg::FL_H] == $past(st_r.flags[bobt_pkg::FL_H]))
		else $error("bit-or flags wrong");
	a_bitor_cycle_count: assert property (
		start_bitor |=> s_bitor_run)
		else $error("bit-or not six cycles");
	a_btj_cycle_count: assert property (
		start_btj |=> s_btj_run)
		else $error("branch not ten cycles");
	a_btj_flag_keep: assert property (
		commit_btj |=> $stable(st_r.flags))
		else $error("branch changed flags");
	a_btj_jump_target: assert property (
		commit_btj && !tested |=> st_r.pc == $past(st_r.pc)
		+ 16'h0003 + {{8{$past(b3[7])}}, $past(b3)} && st_r.taken)
		else $error("branch target wrong");
	a_btj_fall_through: assert property (
		commit_btj && tested |=> st_r.pc == $past(st_r.pc) + 16'h0003
		&& !st_r.taken)
		else $error("fall-through address wrong");
	a_bitor_pc_step: assert property (
		commit_bitor |=> st_r.pc == $past(st_r.pc) + 16'h0003)
		else $error("bit-or program counter step wrong");
	a_foreign_op_idle: assert property (
		go_wr && !st_r.busy && !start_bitor && !start_btj
		|=> !st_r.busy && st_r.bad)
		else $error("foreign opcode was started");
endmodule : bobt_core
`default_nettype wire

// >>> hdl/bobt_pkg.sv
`default_nettype none
package bobt_pkg;
	// ****************************************
	// Bus map
	// ****************************************
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_INSN = 12'h004;
	localparam logic [11:0] OFS_PC = 12'h008;
	localparam logic [11:0] OFS_FLAGS = 12'h00C;
	localparam logic [11:0] OFS_STATUS = 12'h010;
	localparam logic [11:0] OFS_RP = 12'h014;
	localparam logic [1:0] RF_WINDOW = 2'h1;
	localparam int CTRL_GO = 0;
	localparam int CTRL_CLR = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_BAD = 2;
	localparam int ST_TAKEN = 3;
	// ****************************************
	// Flag positions
	// ****************************************
	localparam int FL_C = 7;
	localparam int FL_Z = 6;
	localparam int FL_S = 5;
	localparam int FL_V = 4;
	localparam int FL_D = 3;
	localparam int FL_H = 2;
	// ****************************************
	// Opcodes, lengths, timing
	// ****************************************
	localparam logic [7:0] OPC_BITOR = 8'h07;
	localparam logic [7:0] OPC_BTJ = 8'h37;
	localparam logic [15:0] INSN_LEN = 16'h0003;
	localparam logic [3:0] BITOR_CYCLES = 4'h6;
	localparam logic [3:0] BTJ_CYCLES = 4'hA;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] RP_RST = 8'hC0;
	typedef enum logic {BOBT_IDLE, BOBT_EXEC} bobt_state_t;
	typedef enum logic {BOBT_K_BITOR, BOBT_K_BTJ} bobt_kind_t;
endpackage : bobt_pkg
`default_nettype wire
